// ### rtl/flash_otp_pkg.sv
/*
  Shared constants and types for the wake, identification and security-region
  command block of a serial NOR flash.
  Assumes a 10 MHz system clock and SPI pins that arrive synchronous to it.
*/
package flash_otp_pkg;

  // System clock period
  localparam int CLK_PERIOD_NS = 100;

  // Command opcodes
  localparam logic [7:0] OPC_WAKE_ID = 8'hAB;
  localparam logic [7:0] OPC_READ    = 8'h48;
  localparam logic [7:0] OPC_ERASE   = 8'h44;
  localparam logic [7:0] OPC_PROG    = 8'h42;

  // Bit counts of each frame phase, as last index
  localparam logic [4:0] LEN_CMD      = 5'h07;
  localparam logic [4:0] LEN_ADDR     = 5'h17;
  localparam logic [4:0] LEN_ID_DUMMY = 5'h17;
  localparam logic [4:0] LEN_RD_DUMMY = 5'h07;
  localparam logic [4:0] LEN_BYTE     = 5'h07;

  // Delays and self-timed cycle lengths in their own units
  localparam int WAKE_DELAY_NS         = 3000;
  localparam int WAKE_WITH_ID_DELAY_NS = 1800;
  localparam int SECTOR_ERASE_TIME_US  = 1000;
  localparam int PAGE_PROGRAM_TIME_US  = 500;

  // Same times as clock cycles, least times rounded up
  localparam int WAKE_CYC  = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_ID_CYC = (WAKE_WITH_ID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (SECTOR_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC  = (PAGE_PROGRAM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W   = 24;

  // Region layout
  localparam int         REGION_SIZE  = 256;
  localparam int         REGION_COUNT = 3;
  localparam int         MEM_SIZE     = REGION_SIZE * REGION_COUNT;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // Program data buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // Reset values of the flags
  localparam logic RST_BUSY = 1'b0;
  localparam logic RST_WPL  = 1'b0;
  localparam logic RST_DPD  = 1'b0;

  // Phase of the current SPI frame
  typedef enum logic [2:0] {
    ph_cmd   = 3'b000,
    ph_addr  = 3'b001,
    ph_dummy = 3'b010,
    ph_out   = 3'b011,
    ph_data  = 3'b100,
    ph_end   = 3'b101,
    ph_skip  = 3'b110
  } phase_type;

  // Self-timed engine state
  typedef enum logic [2:0] {
    cyc_idle  = 3'b000,
    cyc_drain = 3'b001,
    cyc_erase = 3'b010,
    cyc_prog  = 3'b011,
    cyc_wake  = 3'b100
  } cycle_type;

endpackage

// ### rtl/otp_byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/1ns
module otp_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Handshake terms
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ### rtl/flash_otp_cmd.sv
/*
  Wake from deep power-down, identification read and three security regions
  (read, erase, program) of a serial NOR flash, device side.
  Assumes SPI pins synchronous to i_clk_sys and sampled at least twice per
  SPI clock phase; shared status flags are plain ports.
*/
// Summary of operation
// R01 - Wake opcode alone with chip select rise wakes after wake delay.
// R02 - Host keeps chip select high during wake delay, no new command.
// R03 - Wake opcode plus three dummies returns ID MSB first on falling edges.
// R04 - ID byte repeats while clocked until chip select rises.
// R05 - ID read in power-down wakes after the identification wake delay.
// R06 - Wake or ID command ignored while a cycle is busy.
// R07 - Region read is opcode, 24-bit address, one dummy, sampled on rises.
// R08 - Read data leaves on falling edges, address incrementing per byte.
// R09 - Low ten address bits roll over from 3FF to 000 during reads.
// R10 - Bits 15..8 pick region 1..3, bits 23..16 zero, 7..0 offset.
// R11 - Three 256-byte regions, each erased and programmed on its own.
// R12 - Erase needs write permit; offset bits ignored.
// R13 - Erase starts only on chip select rise at a byte boundary.
// R14 - Erase is self-timed, busy throughout, write permit cleared early.
// R15 - Erase ignored once the region lock flag is set.
// R16 - Program is opcode, three address bytes, 1 to 256 data bytes.
// R17 - Program ignored while write permit is clear.
// R18 - Program is self-timed, busy throughout, write permit cleared early.
// R19 - Program to a locked region is ignored.
// R20 - In power-down only the wake/ID command is recognised.
// R21 - Program data wraps within the page; last 256 bytes kept.
// R22 - Program executes only if chip select rises after a whole byte.
// R23 - Addresses outside the three regions never erase or program.
`timescale 1ns/1ns
module flash_otp_cmd #(
  parameter int         P_ERASE_CYC = flash_otp_pkg::ERASE_CYC,
  parameter int         P_PROG_CYC  = flash_otp_pkg::PROG_CYC,
  parameter logic [7:0] P_DEVICE_ID = 8'h5A  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // SPI pins
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sck,
  input  wire logic       i_spi_si,
  output logic            o_spi_so,
  output logic            o_spi_so_oe,
  // Shared status
  input  wire logic       i_ext_busy,
  input  wire logic       i_write_permit_set,
  input  wire logic       i_power_down_enter,
  input  wire logic       i_otp_region_lock,
  input  wire logic [2:0] i_per_region_lock_flags,
  output logic            o_cycle_busy_flag,
  output logic            o_write_permit_latch,
  output logic            o_deep_power_down
);

  localparam int TW = flash_otp_pkg::TIMER_W;

  // Reset release through two flip-flops
  logic rst_meta_q, rst_n;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Frame state
  flash_otp_pkg::phase_type ph_q, ph_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  opc_q, opc_d, opc_new, byte_q, byte_d, tx_q, tx_d;
  logic [23:0] addr_q, addr_d;
  logic [9:0]  rptr_q, rptr_d;
  logic [2:0]  bit_q, bit_d;
  logic        cs_q, sck_q, so_q, so_d, oe_q, oe_d, got_q, got_d, bad_q, bad_d;
  // Engine state
  flash_otp_pkg::cycle_type cyc_q, cyc_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [7:0]    mem_q [flash_otp_pkg::MEM_SIZE];
  logic [7:0]    mem_d [flash_otp_pkg::MEM_SIZE];
  logic [7:0]    stage_q [flash_otp_pkg::REGION_SIZE];
  logic [7:0]    stage_d [flash_otp_pkg::REGION_SIZE];
  logic [255:0]  mask_q, mask_d;
  logic [7:0]    wptr_q, wptr_d, wptr_init;
  logic [1:0]    reg_q, reg_d;
  logic          busy_q, busy_d, wpl_q, wpl_d, dpd_q, dpd_d;
  // Links between the groups
  logic sck_rise, sck_fall, cs_rise, busy_any, wptr_load, mask_clear;
  logic start_erase, start_prog, start_wake, start_wake_id;
  logic [7:0] f_in_data, f_out_data;
  logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready;

  assign sck_rise = i_spi_sck & ~sck_q;
  assign sck_fall = ~i_spi_sck & sck_q;
  assign cs_rise  = i_spi_cs_n & ~cs_q;
  assign busy_any = busy_q | i_ext_busy;

  // Region 1..3 from address, upper byte zero
  function automatic logic region_ok(input logic [23:0] a);
    region_ok = (a[23:16] == 8'h00) && (a[15:8] >= 8'h01) && (a[15:8] <= 8'h03);  // see R10
  endfunction

  // Byte seen by a read; outside the regions reads as erased
  function automatic logic [7:0] rd_byte(input logic [23:0] a);
    logic [1:0] r;
    r = a[9:8];
    if ((a[23:10] == 14'h0000) && (r != 2'h0)) begin  // see R10
      rd_byte = mem_q[{r - 2'h1, a[7:0]}];
    end else begin
      rd_byte = flash_otp_pkg::ERASED_BYTE;
    end
  endfunction

  // Frame decode, shift in and shift out
  always_comb begin
    ph_d = ph_q; cnt_d = cnt_q; opc_d = opc_q; byte_d = byte_q; tx_d = tx_q;
    addr_d = addr_q; rptr_d = rptr_q; bit_d = bit_q; so_d = so_q; oe_d = oe_q;
    got_d = got_q; bad_d = bad_q;
    opc_new = {opc_q[6:0], i_spi_si};
    f_in_valid = 1'b0; f_in_data = {byte_q[6:0], i_spi_si};
    wptr_load = 1'b0; wptr_init = {addr_q[6:0], i_spi_si}; mask_clear = 1'b0;
    start_erase = 1'b0; start_prog = 1'b0; start_wake = 1'b0; start_wake_id = 1'b0;
    if (cs_rise) begin
      // Wake alone: exactly eight bits
      start_wake = dpd_q && opc_q == flash_otp_pkg::OPC_WAKE_ID
                   && ph_q == flash_otp_pkg::ph_dummy && cnt_q == 5'h00;  // see R01
      // Wake with identification read
      start_wake_id = dpd_q && opc_q == flash_otp_pkg::OPC_WAKE_ID
                      && ((ph_q == flash_otp_pkg::ph_dummy && cnt_q != 5'h00)
                          || ph_q == flash_otp_pkg::ph_out);  // see R05
      start_erase = opc_q == flash_otp_pkg::OPC_ERASE && ph_q == flash_otp_pkg::ph_end
                    && wpl_q && !i_otp_region_lock && region_ok(addr_q);  // see R12 R13 R15 R23
      start_prog = opc_q == flash_otp_pkg::OPC_PROG && ph_q == flash_otp_pkg::ph_data
                   && cnt_q == 5'h00 && got_q && !bad_q && wpl_q && region_ok(addr_q)
                   && !i_per_region_lock_flags[addr_q[9:8] - 2'h1];  // see R16 R17 R19 R22 R23
    end
    if (i_spi_cs_n) begin
      ph_d = flash_otp_pkg::ph_cmd; cnt_d = 5'h00; oe_d = 1'b0;
      got_d = 1'b0; bad_d = 1'b0; opc_d = 8'h00;
    end else if (sck_rise) begin
      cnt_d = cnt_q + 5'h01;
      case (ph_q)
        flash_otp_pkg::ph_cmd: begin
          opc_d = opc_new;
          if (cnt_q == flash_otp_pkg::LEN_CMD) begin
            cnt_d = 5'h00;
            if (busy_any || cyc_q == flash_otp_pkg::cyc_wake) begin
              ph_d = flash_otp_pkg::ph_skip;  // see R06 R02
            end else if (dpd_q && opc_new != flash_otp_pkg::OPC_WAKE_ID) begin
              ph_d = flash_otp_pkg::ph_skip;  // see R20
            end else if (opc_new == flash_otp_pkg::OPC_WAKE_ID) begin
              ph_d = flash_otp_pkg::ph_dummy;  // see R03
            end else if (opc_new == flash_otp_pkg::OPC_READ
                         || opc_new == flash_otp_pkg::OPC_ERASE) begin
              ph_d = flash_otp_pkg::ph_addr;  // see R07 R12
            end else if (opc_new == flash_otp_pkg::OPC_PROG) begin
              ph_d = flash_otp_pkg::ph_addr;
              mask_clear = 1'b1;
            end else begin
              ph_d = flash_otp_pkg::ph_skip;
            end
          end
        end
        flash_otp_pkg::ph_addr: begin
          addr_d = {addr_q[22:0], i_spi_si};  // see R07
          if (cnt_q == flash_otp_pkg::LEN_ADDR) begin
            cnt_d = 5'h00;
            if (opc_q == flash_otp_pkg::OPC_READ) begin
              ph_d = flash_otp_pkg::ph_dummy;
            end else if (opc_q == flash_otp_pkg::OPC_ERASE) begin
              ph_d = flash_otp_pkg::ph_end;  // see R13
            end else begin
              ph_d = flash_otp_pkg::ph_data;
              wptr_load = 1'b1;
            end
          end
        end
        flash_otp_pkg::ph_dummy: begin
          if (cnt_q == ((opc_q == flash_otp_pkg::OPC_WAKE_ID) ? flash_otp_pkg::LEN_ID_DUMMY
                                                             : flash_otp_pkg::LEN_RD_DUMMY)) begin
            cnt_d = 5'h00;
            ph_d  = flash_otp_pkg::ph_out;
            bit_d = 3'h0;
            tx_d  = (opc_q == flash_otp_pkg::OPC_WAKE_ID) ? P_DEVICE_ID : rd_byte(addr_q);
            rptr_d = addr_q[9:0] + 10'h001;
          end
        end
        flash_otp_pkg::ph_data: begin
          byte_d = f_in_data;
          got_d  = 1'b0;
          if (cnt_q == flash_otp_pkg::LEN_BYTE) begin
            cnt_d = 5'h00;
            got_d = 1'b1;
            f_in_valid = 1'b1;
            if (!f_in_ready) begin
              bad_d = 1'b1;  // Dropped byte spoils the command
            end
          end
        end
        flash_otp_pkg::ph_end: begin
          ph_d = flash_otp_pkg::ph_skip;  // see R13
        end
        flash_otp_pkg::ph_out: begin
          cnt_d = cnt_q;
        end
        flash_otp_pkg::ph_skip: begin
          cnt_d = cnt_q;
        end
        default: begin
          ph_d = flash_otp_pkg::ph_skip;
        end
      endcase
    end else if (sck_fall && ph_q == flash_otp_pkg::ph_out) begin
      so_d  = tx_q[3'h7 - bit_q];  // see R03 R08
      oe_d  = 1'b1;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        tx_d = (opc_q == flash_otp_pkg::OPC_WAKE_ID) ? P_DEVICE_ID  // see R04
                                                     : rd_byte({addr_q[23:10], rptr_q});
        rptr_d = rptr_q + 10'h001;  // see R08 R09
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= flash_otp_pkg::ph_cmd; cnt_q <= 5'h00; opc_q <= 8'h00; byte_q <= 8'h00;
      tx_q <= 8'h00; addr_q <= 24'h000000; rptr_q <= 10'h000; bit_q <= 3'h0;
      so_q <= 1'b0; oe_q <= 1'b0; got_q <= 1'b0; bad_q <= 1'b0;
      cs_q <= 1'b1; sck_q <= 1'b0;
    end else begin
      ph_q <= ph_d; cnt_q <= cnt_d; opc_q <= opc_d; byte_q <= byte_d;
      tx_q <= tx_d; addr_q <= addr_d; rptr_q <= rptr_d; bit_q <= bit_d;
      so_q <= so_d; oe_q <= oe_d; got_q <= got_d; bad_q <= bad_d;
      cs_q <= i_spi_cs_n; sck_q <= i_spi_sck;
    end
  end

  // Program data path buffer
  otp_byte_fifo #(
    .WIDTH (flash_otp_pkg::FIFO_WIDTH),
    .DEPTH (flash_otp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk_sys),
    .i_rst_n     (rst_n),
    .i_in_data   (f_in_data),
    .i_in_valid  (f_in_valid),
    .o_in_ready  (f_in_ready),
    .o_out_data  (f_out_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_out_ready)
  );

  // Staging stalls only while the page is being committed
  assign f_out_ready = (cyc_q != flash_otp_pkg::cyc_prog);

  // Self-timed engine, flags, staging page and regions
  always_comb begin
    cyc_d = cyc_q; timer_d = timer_q; mem_d = mem_q; stage_d = stage_q;
    mask_d = mask_q; wptr_d = wptr_q; reg_d = reg_q;
    busy_d = busy_q; wpl_d = wpl_q; dpd_d = dpd_q;
    if (mask_clear) begin
      mask_d = '0;
    end
    if (wptr_load) begin
      wptr_d = wptr_init;
    end
    if (f_out_valid && f_out_ready) begin
      stage_d[wptr_q] = f_out_data;
      mask_d[wptr_q]  = 1'b1;
      wptr_d = wptr_q + 8'h01;  // see R21
    end
    case (cyc_q)
      flash_otp_pkg::cyc_idle: begin
        if (i_power_down_enter) begin
          dpd_d = 1'b1;
        end
        if (start_erase) begin
          cyc_d = flash_otp_pkg::cyc_erase; busy_d = 1'b1; wpl_d = 1'b0;  // see R14
          timer_d = TW'(P_ERASE_CYC - 1); reg_d = addr_q[9:8] - 2'h1;
        end else if (start_prog) begin
          cyc_d = flash_otp_pkg::cyc_drain; busy_d = 1'b1; wpl_d = 1'b0;  // see R18
          reg_d = addr_q[9:8] - 2'h1;
        end else if (start_wake) begin
          cyc_d = flash_otp_pkg::cyc_wake; timer_d = TW'(flash_otp_pkg::WAKE_CYC - 1);
        end else if (start_wake_id) begin
          cyc_d = flash_otp_pkg::cyc_wake; timer_d = TW'(flash_otp_pkg::WAKE_ID_CYC - 1);
        end
      end
      flash_otp_pkg::cyc_drain: begin
        if (!f_out_valid) begin
          cyc_d = flash_otp_pkg::cyc_prog; timer_d = TW'(P_PROG_CYC - 1);
        end
      end
      flash_otp_pkg::cyc_erase: begin
        timer_d = timer_q - TW'(1);
        if (timer_q == '0) begin
          for (int i = 0; i < flash_otp_pkg::REGION_SIZE; i++) begin
            mem_d[{reg_q, 8'(i)}] = flash_otp_pkg::ERASED_BYTE;  // see R11
          end
          cyc_d = flash_otp_pkg::cyc_idle; busy_d = 1'b0;  // see R14
        end
      end
      flash_otp_pkg::cyc_prog: begin
        timer_d = timer_q - TW'(1);
        if (timer_q == '0) begin
          for (int i = 0; i < flash_otp_pkg::REGION_SIZE; i++) begin
            if (mask_q[i]) begin
              mem_d[{reg_q, 8'(i)}] = mem_q[{reg_q, 8'(i)}] & stage_q[i];  // see R11 R21
            end
          end
          cyc_d = flash_otp_pkg::cyc_idle; busy_d = 1'b0;  // see R18
        end
      end
      flash_otp_pkg::cyc_wake: begin
        timer_d = timer_q - TW'(1);
        if (timer_q == '0) begin
          cyc_d = flash_otp_pkg::cyc_idle; dpd_d = 1'b0;  // see R01 R05
        end
      end
      default: begin
        cyc_d = flash_otp_pkg::cyc_idle; busy_d = 1'b0;
      end
    endcase
    // Set wins over the clear
    if (i_write_permit_set) begin
      wpl_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= flash_otp_pkg::cyc_idle; timer_q <= '0; mask_q <= '0;
      wptr_q <= 8'h00; reg_q <= 2'h0;
      busy_q <= flash_otp_pkg::RST_BUSY; wpl_q <= flash_otp_pkg::RST_WPL;
      dpd_q <= flash_otp_pkg::RST_DPD;
      for (int i = 0; i < flash_otp_pkg::MEM_SIZE; i++) begin
        mem_q[i] <= flash_otp_pkg::ERASED_BYTE;
      end
      for (int i = 0; i < flash_otp_pkg::REGION_SIZE; i++) begin
        stage_q[i] <= flash_otp_pkg::ERASED_BYTE;
      end
    end else begin
      cyc_q <= cyc_d; timer_q <= timer_d; mask_q <= mask_d;
      wptr_q <= wptr_d; reg_q <= reg_d;
      busy_q <= busy_d; wpl_q <= wpl_d; dpd_q <= dpd_d;
      mem_q <= mem_d; stage_q <= stage_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_spi_so             = so_q;
  assign o_spi_so_oe          = oe_q;
  assign o_cycle_busy_flag    = busy_q;
  assign o_write_permit_latch = wpl_q;
  assign o_deep_power_down    = dpd_q;

endmodule

// ### tb/flash_otp_cmd_checker.sv
/*
  Port-level checks for flash_otp_cmd.
  Assumes it is bound into the design and shares its clock and reset.
*/
`timescale 1ns/1ns
module flash_otp_cmd_checker #(
  parameter int P_ERASE_CYC = 20,
  parameter int P_PROG_CYC  = 20
) (
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_arst_n,
  // SPI pins
  input wire logic       i_spi_cs_n,
  input wire logic       i_spi_sck,
  input wire logic       i_spi_si,
  input wire logic       o_spi_so,
  input wire logic       o_spi_so_oe,
  // Shared status
  input wire logic       i_ext_busy,
  input wire logic       i_write_permit_set,
  input wire logic       i_power_down_enter,
  input wire logic       i_otp_region_lock,
  input wire logic [2:0] i_per_region_lock_flags,
  input wire logic       o_cycle_busy_flag,
  input wire logic       o_write_permit_latch,
  input wire logic       o_deep_power_down
);
  localparam int MIN_BUSY = (P_ERASE_CYC < P_PROG_CYC) ? P_ERASE_CYC : P_PROG_CYC;
  localparam int MAX_BUSY = P_ERASE_CYC + P_PROG_CYC + 64;
  int busy_len_q;
  int busy_len_d;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  // Length of the current busy run
  always_comb begin
    busy_len_d = o_cycle_busy_flag ? busy_len_q + 1 : 0;
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_len_q <= 0;
    end else begin
      busy_len_q <= busy_len_d;
    end
  end

  a_busy_cs_rise: assert property (
    $rose(o_cycle_busy_flag) |-> $past(i_spi_cs_n) && !$past(i_spi_cs_n, 2))
    else $error("busy rose without a chip select rise");
  a_busy_latch: assert property (
    $rose(o_cycle_busy_flag) && !$past(i_write_permit_set)
      |-> $past(o_write_permit_latch) && !o_write_permit_latch)
    else $error("cycle start without latch or latch kept");
  a_busy_awake: assert property (
    $rose(o_cycle_busy_flag) |-> !$past(o_deep_power_down))
    else $error("cycle started in power-down");
  a_busy_span: assert property (
    $fell(o_cycle_busy_flag) |-> busy_len_q >= MIN_BUSY && busy_len_q < MAX_BUSY)
    else $error("self-timed cycle length out of range");
  a_quiet_busy: assert property (
    o_cycle_busy_flag |=> !o_spi_so_oe)
    else $error("output driven during a cycle");
  a_oe_cs_high: assert property (
    i_spi_cs_n |=> !o_spi_so_oe)
    else $error("output driven while deselected");
  a_wake_hold: assert property (
    $fell(o_deep_power_down) |-> $past(i_spi_cs_n, 17) && i_spi_cs_n)
    else $error("woke before the wake delay");
  a_latch_set: assert property (
    i_write_permit_set |=> o_write_permit_latch)
    else $error("write permit not set");
endmodule

// ### tb/spi_host_model.sv
/*
  SPI host model: chip select, clock and serial data in.
  Assumes one caller process; sck is 4 system clocks per bit.
*/
`timescale 1ns/1ns
module spi_host_model (
  // Clock and serial return
  input  wire logic i_clk,
  input  wire logic i_so,
  // Pins towards the device
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  // Idle pins at time zero
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  // Whole clocks, moving on falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Select; held low for the whole frame
  task automatic sel();
    tick(1);
    o_cs_n = 1'b0;
    tick(2);
  endtask
  // Release two clocks after the last bit; released data line toggles
  task automatic desel();
    tick(2);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    tick(2);
  endtask
  // Data set while sck low, so taken at the rise
  task automatic xbit(input logic b, output logic r);
    o_si = b;
    tick(2);
    o_sck = 1'b1;
    r = i_so;
    tick(2);
    o_sck = 1'b0;
  endtask
  // One byte, MSB first
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      xbit(t[i], r[i]);
    end
  endtask
endmodule

// ### tb/flash_otp_cmd_tb_top.sv
/*
  Testbench for flash_otp_cmd driven through an SPI host model.
  Assumes short self-timed cycles set by parameter.
*/
`timescale 1ns/1ns
module flash_otp_cmd_tb_top;
  localparam int         P_CYC  = 20;
  localparam logic [7:0] DEV_ID = 8'h3C; // Arbitrary identification value
  localparam logic [7:0] WK = flash_otp_pkg::OPC_WAKE_ID;
  localparam logic [7:0] RD = flash_otp_pkg::OPC_READ;
  localparam logic [7:0] ER = flash_otp_pkg::OPC_ERASE;
  localparam logic [7:0] PG = flash_otp_pkg::OPC_PROG;
  logic       i_clk_sys, i_arst_n, i_spi_cs_n, i_spi_sck, i_spi_si;
  logic       o_spi_so, o_spi_so_oe, i_ext_busy, i_write_permit_set;
  logic       i_power_down_enter, i_otp_region_lock, o_cycle_busy_flag;
  logic       o_write_permit_latch, o_deep_power_down, oe_seen;
  logic [2:0] i_per_region_lock_flags;
  logic [7:0] r;
  int         error_cnt, n_checks;

  // Clock and output-activity monitor
  always #50 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) begin
    if (o_spi_so_oe === 1'b1) oe_seen = 1'b1;
  end

  flash_otp_cmd #(.P_ERASE_CYC(P_CYC), .P_PROG_CYC(P_CYC), .P_DEVICE_ID(DEV_ID))
    flash_otp_cmd_i (.*);
  spi_host_model spi_host_model_i (.i_clk(i_clk_sys), .i_so(o_spi_so_oe ? o_spi_so : ~o_spi_so),
    .o_cs_n(i_spi_cs_n), .o_sck(i_spi_sck), .o_si(i_spi_si));

  // Comparisons and closing report
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Frame: bytes, x extra bits, then n bytes read back into r
  task automatic fr(input logic [7:0] q[$], input int x, input int n);
    logic b;
    spi_host_model_i.sel();
    foreach (q[i]) spi_host_model_i.xb(q[i], r);
    repeat (x) spi_host_model_i.xbit(1'b1, b);
    repeat (n) spi_host_model_i.xb(8'h00, r);
    spi_host_model_i.desel();
  endtask
  task automatic rd(input logic [23:0] a, input int n, input logic [7:0] e);
    fr('{RD, a[23:16], a[15:8], a[7:0], 8'h00}, 0, n);
    chk8(r, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk_sys) s = 1'b1;
    @(negedge i_clk_sys) s = 1'b0;
  endtask
  // Bounded waits for cycle end and for wake-up
  task automatic idle();
    for (int k = 0; k < 200 && o_cycle_busy_flag !== 1'b0; k++) @(negedge i_clk_sys);
    chk1(o_cycle_busy_flag, 1'b0);
    if (o_cycle_busy_flag !== 1'b0) end_of_test();
  endtask
  task automatic wdpd(input int lo);
    int k;
    k = 2;
    while (o_deep_power_down === 1'b1 && k < 100) begin
      @(negedge i_clk_sys);
      k++;
    end
    chk1(k >= lo && k <= lo + 3, 1'b1);
    if (k >= 100) end_of_test();
  endtask
  task automatic started(input logic e);
    chk1(o_cycle_busy_flag, e);
    chk1(o_write_permit_latch, !e);
    if (e) idle();
  endtask

  // Scenarios
  task automatic t_basic();
    chk1(o_deep_power_down, 1'b0);
    rd(24'h000100, 1, 8'hFF);
    fr('{PG, 8'h00, 8'h01, 8'h00, 8'h00}, 0, 0);
    chk1(o_cycle_busy_flag, 1'b0);
    pulse(i_write_permit_set);
    fr('{PG, 8'h00, 8'h02, 8'hFE, 8'hA5, 8'h5C, 8'h0F}, 0, 0);
    started(1'b1);
    rd(24'h0002FE, 2, 8'h5C);
    rd(24'h0002FE, 3, 8'hFF);
    rd(24'h000200, 1, 8'h0F);
    pulse(i_write_permit_set);
    fr('{PG, 8'h00, 8'h01, 8'h00, 8'h11}, 0, 0);
    started(1'b1);
    rd(24'h0003FF, 258, 8'h11);
    rd(24'h010100, 1, 8'hFF);
    $display("test program and read done");
  endtask
  task automatic t_refuse();
    pulse(i_write_permit_set);
    i_otp_region_lock = 1'b1;
    fr('{ER, 8'h00, 8'h01, 8'h00}, 0, 0);
    started(1'b0);
    i_otp_region_lock = 1'b0;
    i_per_region_lock_flags = 3'h1;
    fr('{PG, 8'h00, 8'h01, 8'h00, 8'h00}, 0, 0);
    started(1'b0);
    i_per_region_lock_flags = 3'h0;
    fr('{ER, 8'h00, 8'h04, 8'h00}, 0, 0);
    started(1'b0);
    fr('{ER, 8'h00, 8'h01, 8'h00}, 1, 0);
    started(1'b0);
    fr('{PG, 8'h00, 8'h01, 8'h00, 8'h00}, 7, 0);
    started(1'b0);
    rd(24'h000100, 1, 8'h11);
    fr('{ER, 8'h00, 8'h02, 8'h33}, 0, 0);
    started(1'b1);
    rd(24'h0002FE, 1, 8'hFF);
    rd(24'h000100, 1, 8'h11);
    $display("test refusals and erase done");
  endtask
  task automatic t_wake();
    i_ext_busy = 1'b1;
    oe_seen = 1'b0;
    fr('{WK, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk1(oe_seen, 1'b0);
    i_ext_busy = 1'b0;
    fr('{WK, 8'h00, 8'h00, 8'h00}, 0, 3);
    chk8(r, DEV_ID);
    pulse(i_power_down_enter);
    oe_seen = 1'b0;
    rd(24'h000100, 1, 8'hFF);
    chk1(oe_seen, 1'b0);
    fr('{WK}, 0, 0);
    wdpd(flash_otp_pkg::WAKE_CYC);
    pulse(i_power_down_enter);
    fr('{WK, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk8(r, DEV_ID);
    wdpd(flash_otp_pkg::WAKE_ID_CYC);
    $display("test wake and identification done");
  endtask

  // Reset, then the scenarios in order
  initial begin
    {i_clk_sys, i_arst_n, i_ext_busy, i_write_permit_set} = 4'h0;
    {i_power_down_enter, i_otp_region_lock, oe_seen} = 3'h0;
    i_per_region_lock_flags = 3'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    t_basic();
    t_refuse();
    t_wake();
    end_of_test();
  end
endmodule

bind flash_otp_cmd flash_otp_cmd_checker #(.P_ERASE_CYC(P_ERASE_CYC),
  .P_PROG_CYC(P_PROG_CYC)) flash_otp_cmd_checker_i (.*);
